// *** rtl/icr_irq_regs.sv ***
// interrupt control and peripheral enable registers with apb slave
`timescale 1ns/1ns
`default_nettype none
module icr_irq_regs
    import icr_pkg::*;
#(
    parameter int PINS = ICR_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ICR_ADDR_W-1:0] paddr,
    input wire logic [ICR_DATA_W-1:0] pwdata,
    output logic [ICR_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timerZeroOvf,
    input wire logic extPin,
    input wire logic [PINS-1:0] pinIn,
    input wire logic [7:0] periphFlags,
    input wire logic irqAck,
    input wire logic returnFromIrq,
    output logic coreIrqReq,
    output logic irqOut
);
    typedef struct packed {
        logic [7:1] ctrl;
        logic [7:0] periEn;
        logic [PINS-1:0] pinFlags;
        logic edgeSel;
        logic [ICR_EV_W-1:0] evStat;
        logic [ICR_EV_W-1:0] evMask;
        logic [ICR_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic irqReq;
        logic irqOut;
    } icr_state_t;

    icr_state_t st_r;
    icr_state_t st_nxt;

    icr_edge_if #(.PINS(PINS)) edges ();

    icr_edge_detect #(.PINS(PINS)) u_edge (
        .clk(clk),
        .rst(rst),
        .extPin(extPin),
        .pinIn(pinIn),
        .edge_o(edges)
    );

    // address match, used by the write path; the read path decodes paddr in a case
    function automatic logic isAt(input logic [ICR_ADDR_W-1:0] a,
                                  input logic [ICR_ADDR_W-1:0] ofs);
        isAt = (a == ofs);
    endfunction

    logic setupCyc;
    logic wrEn;
    logic extEdge;
    logic pinAny;
    logic coreSrc;
    logic periSrc;
    logic [ICR_EV_W-1:0] evSet;
    logic [7:0] wrByte;

    // bus phases: read data is captured in setup, writes land at access
    assign setupCyc = psel & ~penable;
    assign wrEn = psel & penable & pwrite & st_r.pready;
    assign wrByte = pwdata[7:0];
    assign extEdge = st_r.edgeSel ? edges.extRise : edges.extFall;
    assign pinAny = |st_r.pinFlags;
    assign coreSrc = (st_r.ctrl[ICR_T0IE] & st_r.ctrl[ICR_T0IF]) |
                     (st_r.ctrl[ICR_INTE] & st_r.ctrl[ICR_EXT_FLAG]) |
                     (st_r.ctrl[ICR_PCH_EN] & pinAny);
    assign periSrc = |(st_r.periEn & periphFlags);
    assign evSet = {irqAck & st_r.ctrl[ICR_GLB_EN], |edges.pinChg,
                    extEdge, timerZeroOvf};

    // next-state: software first, then hardware so events win
    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b1;
        // control bits 7..1 and all enables writable
        if (wrEn && isAt(paddr, ICR_OFS_CTRL)) begin
            st_nxt.ctrl = pwdata[7:1];
        end
        if (wrEn && isAt(paddr, ICR_OFS_PENA)) begin
            st_nxt.periEn = wrByte;
        end
        // per-pin flags clear only by software write of one
        if (wrEn && isAt(paddr, ICR_OFS_PINFLAG)) begin
            st_nxt.pinFlags = st_r.pinFlags & ~pwdata[PINS-1:0];
        end
        if (wrEn && isAt(paddr, ICR_OFS_EDGE)) begin
            st_nxt.edgeSel = pwdata[0];
        end
        if (wrEn && isAt(paddr, ICR_OFS_EVSTAT)) begin
            st_nxt.evStat = st_r.evStat & ~pwdata[ICR_EV_W-1:0];
        end
        if (wrEn && isAt(paddr, ICR_OFS_EVMASK)) begin
            st_nxt.evMask = pwdata[ICR_EV_W-1:0];
        end
        // interrupt taken clears global enable, return sets it
        if (irqAck && st_r.ctrl[ICR_GLB_EN]) begin
            st_nxt.ctrl[ICR_GLB_EN] = 1'b0;
        end
        if (returnFromIrq) begin
            st_nxt.ctrl[ICR_GLB_EN] = 1'b1;
        end
        if (timerZeroOvf) begin
            st_nxt.ctrl[ICR_T0IF] = 1'b1;
        end
        if (extEdge) begin
            st_nxt.ctrl[ICR_EXT_FLAG] = 1'b1;
        end
        st_nxt.pinFlags = st_nxt.pinFlags | edges.pinChg;
        st_nxt.evStat = st_nxt.evStat | evSet;
        st_nxt.irqReq = st_r.ctrl[ICR_GLB_EN] &
            (coreSrc | (st_r.ctrl[ICR_GRP_EN] & periSrc));
        st_nxt.irqOut = |(st_r.evStat & st_r.evMask);
        // read snapshot taken in setup; unmapped reads zero with error
        if (setupCyc) begin
            st_nxt.pslverr = 1'b0;
            case (paddr)
                ICR_OFS_CTRL: begin
                    st_nxt.prdata = {24'h000000, st_r.ctrl, pinAny};
                end
                ICR_OFS_PENA: begin
                    st_nxt.prdata = {24'h000000, st_r.periEn};
                end
                ICR_OFS_PINFLAG: begin
                    st_nxt.prdata = '0;
                    st_nxt.prdata[PINS-1:0] = st_r.pinFlags;
                end
                ICR_OFS_EDGE: begin
                    st_nxt.prdata = {31'h00000000, st_r.edgeSel};
                end
                ICR_OFS_EVSTAT: begin
                    st_nxt.prdata = {28'h0000000, st_r.evStat};
                end
                ICR_OFS_EVMASK: begin
                    st_nxt.prdata = {28'h0000000, st_r.evMask};
                end
                default: begin
                    st_nxt.prdata = '0;
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign coreIrqReq = st_r.irqReq;
    assign irqOut = st_r.irqOut;

    // checks on the register block
    default clocking cb @(posedge clk);
    endclocking

    sequence s_wr_ctrl;
        psel && !penable && pwrite && paddr == ICR_OFS_CTRL
        ##1 psel && penable && pready;
    endsequence

    sequence s_wr_pena;
        psel && !penable && pwrite && paddr == ICR_OFS_PENA
        ##1 psel && penable && pready;
    endsequence

    sequence s_taken;
        irqAck && st_r.ctrl[ICR_GLB_EN] && !returnFromIrq;
    endsequence

    property p_gie_block;
        disable iff (rst) !st_r.ctrl[ICR_GLB_EN] |=> !coreIrqReq;
    endproperty
    a_gie_block: assert property (p_gie_block)
        else $error("request raised with global enable clear");

    property p_peri_gate;
        disable iff (rst)
        (!st_r.ctrl[ICR_GRP_EN] && !coreSrc) |=> !coreIrqReq;
    endproperty
    a_peri_gate: assert property (p_peri_gate)
        else $error("peripheral request passed with group enable clear");

    property p_t0_req;
        disable iff (rst)
        (st_r.ctrl[ICR_GLB_EN] && st_r.ctrl[ICR_T0IE] &&
         st_r.ctrl[ICR_T0IF])
        |=> coreIrqReq;
    endproperty
    a_t0_req: assert property (p_t0_req)
        else $error("enabled timer zero flag gave no request");

    property p_ext_req;
        disable iff (rst)
        (st_r.ctrl[ICR_GLB_EN] && st_r.ctrl[ICR_INTE] &&
         st_r.ctrl[ICR_EXT_FLAG])
        |=> coreIrqReq;
    endproperty
    a_ext_req: assert property (p_ext_req)
        else $error("enabled external flag gave no request");

    property p_pin_req;
        disable iff (rst)
        (st_r.ctrl[ICR_GLB_EN] && st_r.ctrl[ICR_PCH_EN] && pinAny)
        |=> coreIrqReq;
    endproperty
    a_pin_req: assert property (p_pin_req)
        else $error("enabled pin change gave no request");

    property p_ssp_req;
        disable iff (rst)
        (st_r.ctrl[ICR_GLB_EN] && st_r.ctrl[ICR_GRP_EN] &&
         st_r.periEn[ICR_P_SSP] && periphFlags[ICR_P_SSP]) |=> coreIrqReq;
    endproperty
    a_ssp_req: assert property (p_ssp_req)
        else $error("enabled serial port source gave no request");

    property p_t0_flag;
        disable iff (rst) timerZeroOvf |=> st_r.ctrl[ICR_T0IF] [*2];
    endproperty
    a_t0_flag: assert property (p_t0_flag)
        else $error("timer zero flag not set by overflow");

    property p_ext_flag;
        disable iff (rst)
        ((edges.extRise && st_r.edgeSel) || (edges.extFall && !st_r.edgeSel))
        |=> st_r.ctrl[ICR_EXT_FLAG];
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("external flag missed a selected edge");

    property p_summary;
        disable iff (rst)
        (setupCyc && paddr == ICR_OFS_CTRL) |=> prdata[0] == $past(pinAny);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary flag read disagrees with pin flags");

    property p_summary_ro;
        disable iff (rst)
        s_wr_ctrl |=> pinAny == ($past(pinAny) || $past(|edges.pinChg));
    endproperty
    a_summary_ro: assert property (p_summary_ro)
        else $error("control write altered pin change state");

    property p_pena_rw;
        disable iff (rst) s_wr_pena |=> st_r.periEn == $past(wrByte);
    endproperty
    a_pena_rw: assert property (p_pena_rw)
        else $error("peripheral enable write not stored");

    property p_taken;
        disable iff (rst)
        s_taken |=> !st_r.ctrl[ICR_GLB_EN] ##1 !coreIrqReq;
    endproperty
    a_taken: assert property (p_taken)
        else $error("global enable not cleared on interrupt taken");

    property p_set_wins;
        disable iff (rst)
        (wrEn && paddr == ICR_OFS_CTRL && !pwdata[ICR_T0IF] && timerZeroOvf)
        |=> st_r.ctrl[ICR_T0IF];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("software clear beat a timer zero event");

    property p_reset;
        disable iff (1'b0)
        rst |=> (st_r.ctrl == ICR_CTRL_RST && st_r.periEn == ICR_PENA_RST &&
                 !coreIrqReq && !irqOut && !pinAny);
    endproperty
    a_reset: assert property (p_reset)
        else $error("registers not cleared by reset");

    // a peripheral with its enable clear must add nothing to the request
    property p_peri_mask;
        disable iff (rst)
        (!coreSrc && !(|(st_r.periEn & periphFlags))) |=> !coreIrqReq;
    endproperty
    a_peri_mask: assert property (p_peri_mask)
        else $error("peripheral request passed with its enable clear");

    property p_return;
        disable iff (rst) returnFromIrq |=> st_r.ctrl[ICR_GLB_EN];
    endproperty
    a_return: assert property (p_return)
        else $error("global enable not set on return");

    property p_pin_flag;
        disable iff (rst) (|edges.pinChg) |=> pinAny;
    endproperty
    a_pin_flag: assert property (p_pin_flag)
        else $error("pin change did not raise the summary flag");

    // clearing the last per-pin flag with no new change drops the summary
    property p_pin_clear;
        disable iff (rst)
        (wrEn && paddr == ICR_OFS_PINFLAG && !(|edges.pinChg) &&
         (st_r.pinFlags & ~pwdata[PINS-1:0]) == '0) |=> !pinAny;
    endproperty
    a_pin_clear: assert property (p_pin_clear)
        else $error("summary flag stayed set after pin flags cleared");

    // enable bits 5..3 are touched by software only
    property p_ctrl_rw;
        disable iff (rst)
        s_wr_ctrl |=> st_r.ctrl[ICR_PCH_EN +: 3] ==
            $past(pwdata[ICR_PCH_EN +: 3]);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw)
        else $error("control enable write not stored");
endmodule
`default_nettype wire

// *** rtl/icr_pkg.sv ***
// constants shared by the interrupt control register block
//
// Behaviour
// - global enable bit 7 lets requests reach the core; clear blocks all
// - peripheral group enable bit 6 gates every peripheral source
// - peripheral enable bits act only when the group enable is set
// - timer zero overflow enable bit 5 gates the timer zero request
// - external pin enable bit 4 gates the external edge request
// - pin change enable bit 3 gates the pin change request
// - timer zero overflow sets flag bit 2
// - a qualifying external edge sets flag bit 1
// - summary flag bit 0 reads one while any per-pin change flag is set
// - summary flag ignores writes; clears only when all per-pin flags clear
// - both registers reset to zero; control bits 7..1 writable, bit 0 not
// - peripheral enable register holds eight writable source enables
// - each peripheral enable bit lets its source request when set
// - sync serial port enable at bit 3 gates that port's request
// - flags are set on events whatever the enables hold
// - edge select one picks rising edges, zero picks falling edges
// - taking an interrupt clears global enable; return from irq sets it
package icr_pkg;
    localparam int ICR_ADDR_W = 8;
    localparam int ICR_DATA_W = 32;
    localparam int ICR_PINS = 8;
    // byte offsets on the register bus
    localparam logic [7:0] ICR_OFS_CTRL = 8'h00;
    localparam logic [7:0] ICR_OFS_PENA = 8'h04;
    localparam logic [7:0] ICR_OFS_PINFLAG = 8'h08;
    localparam logic [7:0] ICR_OFS_EDGE = 8'h0C;
    localparam logic [7:0] ICR_OFS_EVSTAT = 8'h10;
    localparam logic [7:0] ICR_OFS_EVMASK = 8'h14;
    // irq_control fields
    localparam int ICR_GLB_EN = 7;
    localparam int ICR_GRP_EN = 6;
    localparam int ICR_T0IE = 5;
    localparam int ICR_INTE = 4;
    localparam int ICR_PCH_EN = 3;
    localparam int ICR_T0IF = 2;
    localparam int ICR_EXT_FLAG = 1;
    localparam int ICR_PCH_SUM = 0;
    // peripheral_irq_enable_one fields
    localparam int ICR_P_T1GATE = 7;
    localparam int ICR_P_CONV = 6;
    localparam int ICR_P_SRX = 5;
    localparam int ICR_P_STX = 4;
    localparam int ICR_P_SSP = 3;
    localparam int ICR_P_CMP1 = 2;
    localparam int ICR_P_T2M = 1;
    localparam int ICR_P_T1OVF = 0;
    // event status / mask fields
    localparam int ICR_EV_W = 4;
    localparam int ICR_EV_T0 = 0;
    localparam int ICR_EV_EXT = 1;
    localparam int ICR_EV_PIN = 2;
    localparam int ICR_EV_TAKEN = 3;
    // reset values
    localparam logic [7:1] ICR_CTRL_RST = 7'h00;
    localparam logic [7:0] ICR_PENA_RST = 8'h00;
    localparam logic ICR_EDGE_RST = 1'b0;
    localparam logic [3:0] ICR_EV_RST = 4'h0;
    // input synchroniser length before edges are trusted
    localparam int ICR_ARM_LEN = 3;
endpackage

// *** rtl/icr_edge_if.sv ***
// edge events carried from the pin synchroniser to the register block
`timescale 1ns/1ns
`default_nettype none
interface icr_edge_if #(parameter int PINS = 8);
    logic extRise;
    logic extFall;
    logic [PINS-1:0] pinChg;
    modport src (output extRise, output extFall, output pinChg);
    modport dst (input extRise, input extFall, input pinChg);
endinterface
`default_nettype wire

// *** rtl/icr_edge_detect.sv ***
// two-flop synchronisers and edge detectors for external pins
`timescale 1ns/1ns
`default_nettype none
module icr_edge_detect
    import icr_pkg::*;
#(
    parameter int PINS = ICR_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic extPin,
    input wire logic [PINS-1:0] pinIn,
    icr_edge_if.src edge_o
);
    typedef struct packed {
        logic [PINS:0] s1;
        logic [PINS:0] s2;
        logic [PINS:0] s3;
        logic [ICR_ARM_LEN-1:0] arm;
    } icr_sync_t;

    icr_sync_t st_r;
    icr_sync_t st_nxt;

    // s1 feeds only s2; edges compare s2 against its delayed copy
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {extPin, pinIn};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.arm = {st_r.arm[ICR_ARM_LEN-2:0], 1'b1};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // edges are held off until s3 holds a real sample, so a pin tied high
    // at reset does not look like a rising edge
    assign edge_o.extRise = st_r.arm[ICR_ARM_LEN-1] &
        st_r.s2[PINS] & ~st_r.s3[PINS];
    assign edge_o.extFall = st_r.arm[ICR_ARM_LEN-1] &
        ~st_r.s2[PINS] & st_r.s3[PINS];
    assign edge_o.pinChg = {PINS{st_r.arm[ICR_ARM_LEN-1]}} &
        (st_r.s2[PINS-1:0] ^ st_r.s3[PINS-1:0]);
endmodule
`default_nettype wire

// *** sim/icr_core_model.sv ***
// behavioural processor core that takes and returns from interrupts
`timescale 1ns/1ns
`default_nettype none
module icr_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic [7:0] ackDelay,
    input wire logic [7:0] svcDelay,
    input wire logic coreIrqReq,
    output logic irqAck,
    output logic returnFromIrq
);
    logic [1:0] phase_r;
    logic [7:0] cnt_r;

    // take, serve, return
    // a request that drops before the delay runs out is not taken
    always_ff @(posedge clk) begin
        irqAck <= 1'b0;
        returnFromIrq <= 1'b0;
        if (rst) begin
            phase_r <= 2'h0;
            cnt_r <= 8'h00;
        end else if (phase_r == 2'h0) begin
            cnt_r <= ackDelay;
            if (active && coreIrqReq) begin
                phase_r <= 2'h1;
            end
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01; // slow core: hold off
        end else if (phase_r == 2'h1) begin
            irqAck <= coreIrqReq;
            phase_r <= coreIrqReq ? 2'h2 : 2'h0;
            cnt_r <= svcDelay;
        end else begin
            returnFromIrq <= 1'b1;
            phase_r <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// *** sim/irq_control_and_enable_regs_tb_top.sv ***
// self-checking bench for the interrupt control register block
`timescale 1ns/1ns
`default_nettype none
module irq_control_and_enable_regs_tb_top import icr_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irqAck, returnFromIrq, coreIrqReq, irqOut;
    logic timerZeroOvf = 1'b0;
    logic extPin = 1'b0;
    logic [7:0] pinIn = 8'h00;
    logic [7:0] periphFlags = 8'h00;
    logic coreActive = 1'b0;
    logic [7:0] ackDelay = 8'h00;
    logic [7:0] svcDelay = 8'h14;
    logic [31:0] seed = 32'h3DF7885B;
    logic [31:0] rd;
    logic err;
    logic [7:0] c, p, f, pm;
    logic [23:0] corner [5] = '{24'h7EFFFF, 24'h80FFFF, 24'hC00808,
                                24'hC0F708, 24'hC00202};
    int k;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    icr_irq_regs #(.PINS(8)) dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timerZeroOvf(timerZeroOvf),
        .extPin(extPin), .pinIn(pinIn), .periphFlags(periphFlags),
        .irqAck(irqAck), .returnFromIrq(returnFromIrq),
        .coreIrqReq(coreIrqReq), .irqOut(irqOut)
    );
    icr_core_model core (
        .clk(clk), .rst(rst), .active(coreActive), .ackDelay(ackDelay),
        .svcDelay(svcDelay), .coreIrqReq(coreIrqReq), .irqAck(irqAck),
        .returnFromIrq(returnFromIrq)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // request the core should see for given control, enables and flags
    function automatic logic expReq(input logic [7:0] r, input logic [7:0] e,
                                    input logic [7:0] g);
        return r[7] & ((r[5] & r[2]) | (r[4] & r[1]) | (r[3] & r[0])
                       | (r[6] & (|(e & g))));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; ovf pulses the timer so it meets the write edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic ovf = 1'b0);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        timerZeroOvf <= ovf;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        timerZeroOvf <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(ICR_OFS_CTRL, 32'h0);
        rdchk(ICR_OFS_PENA, 32'h0);
        chk({pready, coreIrqReq, irqOut}, 3'b100);
        // unmapped place: refused, nothing changes
        wr(8'h3C, 32'hFFFFFFFF);
        chk(err, 1'b1);
        rdchk(ICR_OFS_CTRL, 32'h0);
        // timer event with every enable off, then the event line
        apb(1'b0, ICR_OFS_EVMASK, 32'h0, 1'b1);
        waitc(2);
        rdchk(ICR_OFS_CTRL, 32'h04);
        chk(coreIrqReq, 1'b0);
        rdchk(ICR_OFS_EVSTAT, 32'h1);
        chk(irqOut, 1'b0);
        wr(ICR_OFS_EVMASK, 32'h1);
        waitc(2);
        chk(irqOut, 1'b1);
        wr(ICR_OFS_EVSTAT, 32'h1);
        waitc(2);
        chk(irqOut, 1'b0);
        // clearing write meets an overflow: the flag must survive
        apb(1'b1, ICR_OFS_CTRL, 32'h0, 1'b1);
        rdchk(ICR_OFS_CTRL, 32'h04);
        // corner table first, then random enables and flags
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            {c, p, f} = (i < 5) ? corner[i] : seed[23:0];
            periphFlags <= f;
            wr(ICR_OFS_PENA, {24'h0, p});
            wr(ICR_OFS_CTRL, {24'h0, c});
            waitc(2);
            chk(coreIrqReq, expReq(c & 8'hFE, p, f));
            rdchk(ICR_OFS_CTRL, {24'h0, c & 8'hFE});
            rdchk(ICR_OFS_PENA, {24'h0, p});
        end
        // external pin: rising with select 1, falling with select 0, rising ignored with select 0
        wr(ICR_OFS_CTRL, 32'h0);
        wr(ICR_OFS_EDGE, 32'h1);
        extPin <= 1'b1;
        waitc(8);
        rdchk(ICR_OFS_CTRL, 32'h02);
        wr(ICR_OFS_CTRL, 32'h0);
        wr(ICR_OFS_EDGE, 32'h0);
        extPin <= 1'b0;
        waitc(8);
        rdchk(ICR_OFS_CTRL, 32'h02);
        wr(ICR_OFS_CTRL, 32'h0);
        extPin <= 1'b1;
        waitc(8);
        rdchk(ICR_OFS_CTRL, 32'h0);
        // pin change on one random pin
        pm = 8'h01 << seed[2:0];
        pinIn <= pm;
        waitc(8);
        rdchk(ICR_OFS_PINFLAG, {24'h0, pm});
        wr(ICR_OFS_CTRL, 32'h88);
        waitc(2);
        chk(coreIrqReq, 1'b1);
        wr(ICR_OFS_CTRL, 32'h0);
        rdchk(ICR_OFS_CTRL, 32'h01);
        wr(ICR_OFS_PINFLAG, {24'h0, pm});
        rdchk(ICR_OFS_CTRL, 32'h0);
        // core takes the interrupt, promptly and then slowly
        for (int j = 0; j < 2; j++) begin
            ackDelay <= (j == 0) ? 8'h00 : 8'h06;
            coreActive <= 1'b1;
            wr(ICR_OFS_CTRL, 32'hA4);
            k = 0;
            while (irqAck !== 1'b1 && k < 100) begin
                @(posedge clk);
                k++;
            end
            waitc(2);
            chk(coreIrqReq, 1'b0);
            rdchk(ICR_OFS_CTRL, 32'h24);
            wr(ICR_OFS_CTRL, 32'h20);
            k = 0;
            while (returnFromIrq !== 1'b1 && k < 100) begin
                @(posedge clk);
                k++;
            end
            waitc(2);
            rdchk(ICR_OFS_CTRL, 32'hA0);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
